// *** rtl/chfd_params.svh ***
// offsets, fields, write masks, reset values, fifo depth and descriptor size of the fifo and dma control block
// Notes on behaviour
// - burst code 0..7 selects 1,4,8,16,32,64,128,256 words per transfer.
// - fill above receive threshold: dma request in dma mode, else enabled interrupt.
// - fill at or below transmit threshold: dma request in dma mode, else interrupt.
// - write-protect register bit 0 shows the card write-protect input level.
// - read-only 32-bit count of bytes sent from card interface unit to card.
// - read-only 32-bit count of bytes moved between host side and fifo.
// - bus-mode bits 10:8 mirror the programmed burst-size code, read-only.
// - bus-mode bit 7 switches the descriptor dma on or off.
// - 5-bit skip length spaces unchained descriptors by that many words, in every mode.
// - bus-mode bit 1 makes dma bus transfers fixed-length bursts.
// - writing bus-mode bit 0 resets the dma controller, bit then self-clears.
// - descriptor without ownership bit suspends the dma, fetching stops.
// - any write to poll-demand register restarts descriptor fetching after suspension.
// - descriptor walk starts at the programmed list start address, word aligned.
// - status shows fifo full, empty, transmit and receive threshold conditions.
`ifndef CHFD_PARAMS_SVH
`define CHFD_PARAMS_SVH
`define CHFD_ADDR_FIFO_THRESHOLD 8'h4c
`define CHFD_ADDR_WRITE_PROTECT 8'h54
`define CHFD_ADDR_CARD_BYTES 8'h5c
`define CHFD_ADDR_HOST_BYTES 8'h60
`define CHFD_ADDR_BUS_MODE 8'h80
`define CHFD_ADDR_POLL_DEMAND 8'h84
`define CHFD_ADDR_LIST_BASE 8'h88
`define CHFD_ADDR_IRQ_STATUS 8'ha0
`define CHFD_ADDR_IRQ_MASK 8'ha4
`define CHFD_ADDR_FIFO_STATUS 8'ha8
`define CHFD_RESET_WORD 32'h0000_0000
`define CHFD_FIFO_DEPTH 13'h0400
`define CHFD_DESC_BYTES 32'h0000_0010
`define CHFD_FTH_WRITE_MASK 32'h7fff_0fff
`define CHFD_DMA_BUS_MODE_WRITE_MASK 32'h0000_00fe
`define CHFD_IRQ_BITS 3
`define CHFD_IRQ_RX 0
`define CHFD_IRQ_TX 1
`define CHFD_IRQ_SUSPEND 2
`define CHFD_DMA_BUS_MODE_SWR 0
`define CHFD_DMA_BUS_MODE_FB 1
`define CHFD_DMA_BUS_MODE_DE 7
`endif

// *** rtl/chfd_pkg.sv ***
// types of the fifo and dma control block
package chfd_pkg;
	typedef enum logic [3:0] {
		CHFD_IDLE = 4'b0000,
		CHFD_SUSPEND = 4'b0001,
		CHFD_DESC_RD = 4'b0010,
		CHFD_DESC_CHK = 4'b0011,
		CHFD_DATA = 4'b0110,
		CHFD_DESC_CLOSE = 4'b1000
	} chfd_dma_state_e;

	function automatic logic [8:0] chfd_burst_words(input logic [2:0] code);
		chfd_burst_words = (code == 3'h0) ? 9'h001 : 9'(9'h002 << code);
	endfunction : chfd_burst_words
endpackage : chfd_pkg

// *** rtl/chfd_fetch_if.sv ***
// signals between the register block and the descriptor fetch engine
`timescale 1ns/1ps
interface chfd_fetch_if;
	import chfd_pkg::*;
	logic enable;
	logic soft_reset;
	logic poll;
	logic [31:0] base_addr;
	logic [4:0] skip_len;
	logic rd_req;
	logic [31:0] rd_addr;
	logic rd_valid;
	logic rd_own;
	logic rd_chained;
	logic [31:0] rd_next_addr;
	logic desc_done;
	logic suspend_evt;
	logic desc_active;
	chfd_dma_state_e state;
	modport regs(output enable, soft_reset, poll, base_addr, skip_len, rd_valid, rd_own,
		rd_chained, rd_next_addr, desc_done, input rd_req, rd_addr, suspend_evt,
		desc_active, state);
	modport engine(input enable, soft_reset, poll, base_addr, skip_len, rd_valid, rd_own,
		rd_chained, rd_next_addr, desc_done, output rd_req, rd_addr, suspend_evt,
		desc_active, state);
endinterface : chfd_fetch_if

// *** rtl/chfd_desc_fetch.sv ***
// descriptor fetch engine of the built-in dma
`timescale 1ns/1ps
module chfd_desc_fetch
	import chfd_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	chfd_fetch_if.engine fi
);
	`include "chfd_params.svh"
	chfd_dma_state_e state;
	chfd_dma_state_e next_state;
	logic [31:0] addr;
	logic [31:0] next_addr;
	logic own;
	logic chained;
	logic [31:0] step_addr;
	logic [31:0] chain_addr;
	logic [31:0] start_addr;

	assign start_addr = {fi.base_addr[31:2], 2'b00};
	assign chain_addr = {fi.rd_next_addr[31:2], 2'b00};
	assign step_addr = addr + `CHFD_DESC_BYTES + {25'h0, fi.skip_len, 2'b00};

	always_comb begin
		next_state = state;
		next_addr = addr;
		case (state)
			CHFD_IDLE: begin
				next_addr = start_addr;
				next_state = CHFD_DESC_RD;
			end
			CHFD_DESC_RD: begin
				if (fi.rd_valid) begin
					next_state = CHFD_DESC_CHK;
				end
			end
			CHFD_DESC_CHK: begin
				next_state = own ? CHFD_DATA : CHFD_SUSPEND;
			end
			CHFD_SUSPEND: begin
				if (fi.poll) begin
					next_state = CHFD_DESC_RD;
				end
			end
			CHFD_DATA: begin
				if (fi.desc_done) begin
					next_state = CHFD_DESC_CLOSE;
				end
			end
			CHFD_DESC_CLOSE: begin
				next_addr = chained ? chain_addr : step_addr;
				next_state = CHFD_DESC_RD;
			end
			default: begin
				next_state = CHFD_IDLE;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= CHFD_IDLE;
			addr <= 32'h0;
			own <= 1'b0;
			chained <= 1'b0;
		end else if (fi.soft_reset || !fi.enable) begin
			state <= CHFD_IDLE;
			addr <= 32'h0;
			own <= 1'b0;
			chained <= 1'b0;
		end else begin
			state <= next_state;
			addr <= next_addr;
			if (state == CHFD_DESC_RD && fi.rd_valid) begin
				own <= fi.rd_own;
				chained <= fi.rd_chained;
			end
		end
	end

	assign fi.state = state;
	assign fi.rd_addr = addr;
	assign fi.rd_req = (state == CHFD_DESC_RD);
	assign fi.desc_active = (state == CHFD_DATA);
	assign fi.suspend_evt = (state == CHFD_DESC_CHK) && !own;
endmodule : chfd_desc_fetch

// *** rtl/chfd_top.sv ***
// fifo threshold and built-in dma control registers with apb slave
//
// Chosen here: the APB interface to the registers.
`timescale 1ns/1ps
module chfd_top
	import chfd_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [12:0] fifo_count,
	input wire logic xfer_to_card,
	input wire logic xfer_start,
	input wire logic card_write_protect,
	input wire logic card_bytes_valid,
	input wire logic [3:0] card_bytes,
	input wire logic host_bytes_valid,
	input wire logic [3:0] host_bytes,
	input wire logic desc_rd_valid,
	input wire logic desc_rd_own,
	input wire logic desc_rd_chained,
	input wire logic [31:0] desc_rd_next_addr,
	input wire logic desc_done,
	output logic desc_rd_req,
	output logic [31:0] desc_rd_addr,
	output logic dma_req,
	output logic [8:0] burst_words,
	output logic fixed_length_bursts,
	output logic dma_on_switch,
	output logic dma_soft_reset,
	output logic irq
);
	`include "chfd_params.svh"
	chfd_fetch_if fi();

	logic [31:0] fifo_threshold_config;
	logic [31:0] dma_bus_mode;
	logic [31:0] descriptor_list_base;
	logic [31:0] card_side_byte_count;
	logic [31:0] host_side_byte_count;
	logic [`CHFD_IRQ_BITS-1:0] irq_status;
	logic [`CHFD_IRQ_BITS-1:0] irq_mask;
	logic [`CHFD_IRQ_BITS-1:0] irq_set;
	logic [`CHFD_IRQ_BITS-1:0] irq_clear;
	logic [`CHFD_IRQ_BITS-1:0] next_irq_status;
	logic write_protect_level;
	logic descriptor_poll_demand;
	logic soft_reset_pend;
	logic [31:0] next_prdata;
	logic [31:0] wmask;
	logic [31:0] fth_wdata;
	logic [31:0] dma_bus_mode_wdata;
	logic [31:0] fth_rd;
	logic [31:0] dma_bus_mode_rd;
	logic [31:0] wp_rd;
	logic [31:0] fstat_rd;
	logic [11:0] receive_threshold;
	logic [11:0] transmit_threshold;
	logic [2:0] burst_code;
	logic [4:0] descriptor_skip_length;
	logic rx_level;
	logic tx_level;
	logic fifo_full;
	logic fifo_empty;
	logic setup;
	logic access;
	logic wr_en;
	logic hit_fth;
	logic hit_wp;
	logic hit_cbc;
	logic hit_hbc;
	logic hit_dma_bus_mode;
	logic hit_poll;
	logic hit_base;
	logic hit_ists;
	logic hit_imsk;
	logic hit_fsts;
	logic mapped;
	logic bad_access;
	logic next_dma_req;
	logic resume_fetch_write;

	// apb phase decode
	assign setup = psel && !penable;
	assign access = psel && penable && pready;
	assign wr_en = access && pwrite && !pslverr;
	assign hit_fth = (paddr == `CHFD_ADDR_FIFO_THRESHOLD);
	assign hit_wp = (paddr == `CHFD_ADDR_WRITE_PROTECT);
	assign hit_cbc = (paddr == `CHFD_ADDR_CARD_BYTES);
	assign hit_hbc = (paddr == `CHFD_ADDR_HOST_BYTES);
	assign hit_dma_bus_mode = (paddr == `CHFD_ADDR_BUS_MODE);
	assign hit_poll = (paddr == `CHFD_ADDR_POLL_DEMAND);
	assign hit_base = (paddr == `CHFD_ADDR_LIST_BASE);
	assign hit_ists = (paddr == `CHFD_ADDR_IRQ_STATUS);
	assign hit_imsk = (paddr == `CHFD_ADDR_IRQ_MASK);
	assign hit_fsts = (paddr == `CHFD_ADDR_FIFO_STATUS);
	assign mapped = hit_fth || hit_wp || hit_cbc || hit_hbc || hit_dma_bus_mode || hit_poll ||
		hit_base || hit_ists || hit_imsk || hit_fsts;
	// read-only and write-only words refuse the wrong direction
	assign bad_access = !mapped || (pwrite && (hit_wp || hit_cbc || hit_hbc || hit_fsts)) ||
		(!pwrite && hit_poll);
	assign wmask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};

	// field views of the threshold and bus-mode registers
	assign burst_code = fifo_threshold_config[30:28];
	assign receive_threshold = fifo_threshold_config[27:16];
	assign transmit_threshold = fifo_threshold_config[11:0];
	assign descriptor_skip_length = dma_bus_mode[6:2];

	assign rx_level = fifo_count > {1'b0, receive_threshold};
	assign tx_level = fifo_count <= {1'b0, transmit_threshold};
	assign fifo_full = fifo_count >= `CHFD_FIFO_DEPTH;
	assign fifo_empty = fifo_count == 13'h0000;

	assign next_dma_req = dma_bus_mode[`CHFD_DMA_BUS_MODE_DE] &&
		(xfer_to_card ? tx_level : rx_level);

	// byte-lane merge for the threshold and bus-mode words
	assign fth_wdata = (fifo_threshold_config & ~(wmask & `CHFD_FTH_WRITE_MASK)) |
		(pwdata & wmask & `CHFD_FTH_WRITE_MASK);
	assign dma_bus_mode_wdata = (dma_bus_mode & ~(wmask & `CHFD_DMA_BUS_MODE_WRITE_MASK)) |
		(pwdata & wmask & `CHFD_DMA_BUS_MODE_WRITE_MASK);

	assign dma_bus_mode_rd = {21'h0, burst_code, dma_bus_mode[7:1], soft_reset_pend};
	assign fth_rd = {1'b0, fifo_threshold_config[30:16], 4'h0, transmit_threshold};
	assign wp_rd = {31'h0, write_protect_level};
	assign fstat_rd = {fifo_count, 15'h0, fifo_full, fifo_empty, tx_level, rx_level};

	always_comb begin
		next_prdata = 32'h0;
		case (1'b1)
			hit_fth: next_prdata = fth_rd;
			hit_wp: next_prdata = wp_rd;
			hit_cbc: next_prdata = card_side_byte_count;
			hit_hbc: next_prdata = host_side_byte_count;
			hit_dma_bus_mode: next_prdata = dma_bus_mode_rd;
			hit_base: next_prdata = descriptor_list_base;
			hit_ists: next_prdata = {29'h0, irq_status};
			hit_imsk: next_prdata = {29'h0, irq_mask};
			hit_fsts: next_prdata = fstat_rd;
			default: next_prdata = 32'h0;
		endcase
	end

	// apb answer one cycle after setup
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= `CHFD_RESET_WORD;
		end else begin
			pready <= setup;
			pslverr <= setup && bad_access;
			if (setup) begin
				prdata <= (pwrite || bad_access) ? 32'h0 : next_prdata;
			end
		end
	end

	// writable configuration words
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fifo_threshold_config <= `CHFD_RESET_WORD;
			dma_bus_mode <= `CHFD_RESET_WORD;
			descriptor_list_base <= `CHFD_RESET_WORD;
			irq_mask <= 3'h0;
		end else if (wr_en) begin
			if (hit_fth) begin
				fifo_threshold_config <= fth_wdata;
			end
			if (hit_dma_bus_mode) begin
				dma_bus_mode <= dma_bus_mode_wdata;
			end
			if (hit_base) begin
				descriptor_list_base <= pwdata;
			end
			if (hit_imsk) begin
				irq_mask <= pwdata[`CHFD_IRQ_BITS-1:0];
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			soft_reset_pend <= 1'b0;
		end else begin
			soft_reset_pend <= wr_en && hit_dma_bus_mode && pstrb[0] && pwdata[`CHFD_DMA_BUS_MODE_SWR];
		end
	end

	assign resume_fetch_write = wr_en && hit_poll;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			descriptor_poll_demand <= 1'b0;
		end else begin
			descriptor_poll_demand <= resume_fetch_write;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			card_side_byte_count <= `CHFD_RESET_WORD;
			host_side_byte_count <= `CHFD_RESET_WORD;
		end else if (xfer_start) begin
			card_side_byte_count <= 32'h0;
			host_side_byte_count <= 32'h0;
		end else begin
			if (card_bytes_valid) begin
				card_side_byte_count <= card_side_byte_count + {28'h0, card_bytes};
			end
			if (host_bytes_valid) begin
				host_side_byte_count <= host_side_byte_count + {28'h0, host_bytes};
			end
		end
	end

	assign irq_set[`CHFD_IRQ_RX] = !dma_bus_mode[`CHFD_DMA_BUS_MODE_DE] && !xfer_to_card && rx_level;
	assign irq_set[`CHFD_IRQ_TX] = !dma_bus_mode[`CHFD_DMA_BUS_MODE_DE] && xfer_to_card && tx_level;
	assign irq_set[`CHFD_IRQ_SUSPEND] = fi.suspend_evt;
	assign irq_clear = (wr_en && hit_ists) ? pwdata[`CHFD_IRQ_BITS-1:0] : 3'h0;
	// set wins over clear
	assign next_irq_status = (irq_status & ~irq_clear) | irq_set;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_status <= 3'h0;
			irq <= 1'b0;
		end else begin
			irq_status <= next_irq_status;
			irq <= |(next_irq_status & irq_mask);
		end
	end

	// registered outputs and pin sampling
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			write_protect_level <= 1'b0;
			dma_req <= 1'b0;
			burst_words <= 9'h001;
			fixed_length_bursts <= 1'b0;
			dma_on_switch <= 1'b0;
			dma_soft_reset <= 1'b0;
			desc_rd_req <= 1'b0;
			desc_rd_addr <= 32'h0;
		end else begin
			write_protect_level <= card_write_protect;
			dma_req <= next_dma_req;
			burst_words <= chfd_burst_words(burst_code);
			fixed_length_bursts <= dma_bus_mode[`CHFD_DMA_BUS_MODE_FB];
			dma_on_switch <= dma_bus_mode[`CHFD_DMA_BUS_MODE_DE];
			dma_soft_reset <= soft_reset_pend;
			desc_rd_req <= fi.rd_req && !desc_rd_valid && dma_bus_mode[`CHFD_DMA_BUS_MODE_DE];
			desc_rd_addr <= fi.rd_addr;
		end
	end

	// engine hookup
	assign fi.enable = dma_bus_mode[`CHFD_DMA_BUS_MODE_DE];
	assign fi.soft_reset = soft_reset_pend;
	assign fi.poll = descriptor_poll_demand;
	assign fi.base_addr = descriptor_list_base;
	assign fi.skip_len = descriptor_skip_length;
	assign fi.rd_valid = desc_rd_valid && desc_rd_req;
	assign fi.rd_own = desc_rd_own;
	assign fi.rd_chained = desc_rd_chained;
	assign fi.rd_next_addr = desc_rd_next_addr;
	assign fi.desc_done = desc_done;

	chfd_desc_fetch u_fetch (
		.pclk(pclk),
		.presetn(presetn),
		.fi(fi)
	);
endmodule : chfd_top

// *** verif/chfd_sva.sv ***
// checker of the fifo threshold and dma control block
`timescale 1ns/1ps
module chfd_sva (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	input wire logic [12:0] fifo_count,
	input wire logic xfer_to_card,
	input wire logic desc_rd_valid,
	input wire logic desc_rd_own,
	input wire logic desc_rd_req,
	input wire logic [31:0] desc_rd_addr,
	input wire logic dma_req,
	input wire logic [8:0] burst_words,
	input wire logic fixed_length_bursts,
	input wire logic dma_on_switch,
	input wire logic dma_soft_reset
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic wr, wfth, wbm, wpoll, thr, susp;
	logic [11:0] rxt, txt;
	logic [8:0] bw;
	assign wr = psel && penable && pready && pwrite;
	assign wfth = wr && paddr == 8'h4c;
	assign wbm = wr && paddr == 8'h80;
	assign wpoll = wr && paddr == 8'h84;
	assign bw = (pwdata[30:28] == 3'h0) ? 9'h001 : 9'(9'h002 << pwdata[30:28]);
	assign thr = xfer_to_card ? fifo_count <= {1'b0, txt} : fifo_count > {1'b0, rxt};
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rxt <= 12'h000;
			txt <= 12'h000;
			susp <= 1'b0;
		end else begin
			if (wfth) begin
				rxt <= pwdata[27:16];
				txt <= pwdata[11:0];
			end
			if (desc_rd_valid && !desc_rd_own)
				susp <= 1'b1;
			else if (desc_rd_req)
				susp <= 1'b0;
		end
	end
	AST_APB_ONE_WAIT: assert property (psel && !penable |=> pready ##1 !pready)
		else $error("apb answer not one cycle after setup");
	AST_BURST_DECODE: assert property (wfth |-> ##2 burst_words == $past(bw, 2))
		else $error("burst words do not match burst code");
	AST_DMA_REQ_LEVEL: assert property (1'b1 |=> dma_req == (dma_on_switch && $past(thr)))
		else $error("dma request does not follow fifo level");
	AST_DE_SWITCH: assert property (wbm |-> ##2 dma_on_switch == $past(pwdata[7], 2))
		else $error("dma switch does not follow write");
	AST_FIXED_BURST: assert property (wbm |-> ##2 fixed_length_bursts == $past(pwdata[1], 2))
		else $error("fixed burst does not follow write");
	AST_SOFT_RESET_PULSE: assert property (wbm && pwdata[0] |->
		##[1:3] dma_soft_reset ##1 !dma_soft_reset)
		else $error("soft reset pulse missing");
	AST_SUSPEND_HOLDS: assert property (desc_rd_valid && !desc_rd_own |=> !desc_rd_req [*4])
		else $error("fetch goes on after unowned descriptor");
	AST_POLL_RESUMES: assert property (wpoll && susp && dma_on_switch |-> ##[1:6] desc_rd_req)
		else $error("poll demand did not restart fetch");
	AST_ADDR_ALIGNED: assert property (desc_rd_req |-> desc_rd_addr[1:0] == 2'b00)
		else $error("fetch address not word aligned");
endmodule : chfd_sva

// *** verif/chfd_desc_mem.sv ***
// descriptor memory model answering fetch requests
`timescale 1ns/1ps
module chfd_desc_mem (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic desc_rd_req,
	input wire logic [31:0] desc_rd_addr,
	input wire logic own,
	input wire logic [3:0] lat,
	output logic desc_rd_valid,
	output logic desc_rd_own,
	output logic [31:0] desc_rd_next_addr,
	output logic [31:0] last_addr
);
	logic [3:0] cnt;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt <= 4'h0;
			desc_rd_valid <= 1'b0;
			desc_rd_own <= 1'b0;
			desc_rd_next_addr <= 32'h0;
			last_addr <= 32'h0;
		end else begin
			desc_rd_valid <= 1'b0;
			desc_rd_own <= ~desc_rd_own;
			desc_rd_next_addr <= ~desc_rd_next_addr;
			if (desc_rd_req && !desc_rd_valid && cnt == lat) begin
				desc_rd_valid <= 1'b1;
				desc_rd_own <= own;
				last_addr <= desc_rd_addr;
				cnt <= 4'h0;
			end else if (desc_rd_req && !desc_rd_valid)
				cnt <= cnt + 4'h1;
		end
	end
endmodule : chfd_desc_mem

// *** verif/chfd_top_tb.sv ***
// self-checking bench of the fifo threshold and dma control block
`timescale 1ns/1ps
module chfd_top_tb;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [3:0] pstrb = 4'hf;
	logic [31:0] prdata, desc_rd_next_addr, desc_rd_addr, last_addr, rdat;
	logic pready, pslverr, desc_rd_valid, desc_rd_own, desc_rd_req, dma_req, irq, rerr;
	logic fixed_length_bursts, dma_on_switch, dma_soft_reset;
	logic [8:0] burst_words;
	logic [12:0] fifo_count = 13'h0;
	logic xfer_to_card = 1'b0, xfer_start = 1'b0, card_write_protect = 1'b0, desc_done = 1'b0;
	logic card_bytes_valid = 1'b0, host_bytes_valid = 1'b0, own = 1'b0;
	logic [3:0] card_bytes = 4'h0, host_bytes = 4'h0, lat = 4'h3;
	int n_mismatch = 0, checked = 0;
	chfd_top u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
		.pready, .pslverr, .fifo_count, .xfer_to_card, .xfer_start, .card_write_protect,
		.card_bytes_valid, .card_bytes, .host_bytes_valid, .host_bytes, .desc_rd_valid,
		.desc_rd_own, .desc_rd_chained(1'b0), .desc_rd_next_addr, .desc_done, .desc_rd_req,
		.desc_rd_addr, .dma_req, .burst_words, .fixed_length_bursts, .dma_on_switch,
		.dma_soft_reset, .irq);
	chfd_desc_mem u_mem (.pclk, .presetn, .desc_rd_req, .desc_rd_addr, .own, .lat,
		.desc_rd_valid, .desc_rd_own, .desc_rd_next_addr, .last_addr);
	always #5 pclk = ~pclk;
	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : report_and_stop
	task automatic time_out();
		n_mismatch++;
		report_and_stop();
	endtask : time_out
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		checked++;
		if (s !== e) begin
			n_mismatch++;
			$display("wrong value at %0t: seen %h expected %h", $time, s, e);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (i = 0; i < 20; i++) begin
			@(posedge pclk);
			if (pready === 1'b1)
				break;
		end
		if (i == 20)
			time_out();
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(rdat, e);
	endtask : rd
	task automatic wv();
		int i;
		for (i = 0; i < 40; i++) begin
			@(posedge pclk);
			if (desc_rd_valid === 1'b1)
				return;
		end
		time_out();
	endtask : wv
	task automatic lvl(input logic t, input logic [12:0] c, input logic e);
		xfer_to_card <= t;
		fifo_count <= c;
		repeat (2) @(posedge pclk);
		chk({31'h0, dma_req}, {31'h0, e});
	endtask : lvl
	task automatic t_reset();
		logic [7:0] m [7];
		int i;
		m = '{8'h4c, 8'h54, 8'h5c, 8'h60, 8'h80, 8'h88, 8'ha0};
		chk({23'h0, burst_words}, 32'h1);
		for (i = 0; i < 7; i++)
			rd(m[i], 32'h0);
	endtask : t_reset
	task automatic t_burst();
		logic [8:0] bw [8];
		int k;
		bw = '{9'h001, 9'h004, 9'h008, 9'h010, 9'h020, 9'h040, 9'h080, 9'h100};
		for (k = 0; k < 8; k++) begin
			wr(8'h4c, {1'b0, 3'(k), 28'h0});
			@(posedge pclk);
			chk({23'h0, burst_words}, {23'h0, bw[k]});
			rd(8'h80, {21'h0, 3'(k), 8'h0});
		end
		wr(8'h4c, 32'hffff_ffff);
		rd(8'h4c, 32'h7fff_0fff);
	endtask : t_burst
	task automatic t_wp_count();
		card_write_protect <= 1'b1;
		card_bytes_valid <= 1'b1;
		card_bytes <= 4'h4;
		host_bytes_valid <= 1'b1;
		host_bytes <= 4'hf;
		@(posedge pclk);
		card_bytes <= 4'h3;
		host_bytes_valid <= 1'b0;
		@(posedge pclk);
		card_bytes_valid <= 1'b0;
		rd(8'h54, 32'h1);
		rd(8'h5c, 32'h7);
		apb(1'b1, 8'h60, 32'h0);
		chk({31'h0, rerr}, 32'h1);
		apb(1'b0, 8'hfc, 32'h0);
		chk({31'h0, rerr}, 32'h1);
		rd(8'h60, 32'hf);
		xfer_start <= 1'b1;
		@(posedge pclk);
		xfer_start <= 1'b0;
		rd(8'h5c, 32'h0);
	endtask : t_wp_count
	task automatic t_level();
		wr(8'h4c, 32'h0005_0003);
		wr(8'h80, 32'h80);
		lvl(1'b1, 13'h3, 1'b1);
		lvl(1'b1, 13'h4, 1'b0);
		lvl(1'b0, 13'h5, 1'b0);
		lvl(1'b0, 13'h6, 1'b1);
		wr(8'h80, 32'h0);
		wr(8'ha0, 32'h7);
		rd(8'ha8, 32'h0030_0001);
		wr(8'ha4, 32'h1);
		@(posedge pclk);
		chk({31'h0, irq}, 32'h1);
		wr(8'ha4, 32'h0);
		@(posedge pclk);
		chk({31'h0, irq}, 32'h0);
		lvl(1'b1, 13'h0, 1'b0);
		wr(8'ha0, 32'h7);
		rd(8'ha8, 32'h6);
		rd(8'ha0, 32'h2);
	endtask : t_level
	task automatic t_desc();
		wr(8'h88, 32'h1003);
		rd(8'h88, 32'h1003);
		wr(8'ha4, 32'h4);
		wr(8'h80, 32'h8a);
		wv();
		chk(last_addr, 32'h1000);
		chk({30'h0, dma_on_switch, fixed_length_bursts}, 32'h3);
		rd(8'h80, 32'h8a);
		chk({31'h0, desc_rd_req}, 32'h0);
		chk({31'h0, irq}, 32'h1);
		wr(8'ha0, 32'h4);
		chk({31'h0, irq}, 32'h0);
		own <= 1'b1;
		wr(8'h84, 32'h0);
		wv();
		chk(last_addr, 32'h1000);
		@(posedge pclk);
		desc_done <= 1'b1;
		@(posedge pclk);
		desc_done <= 1'b0;
		wv();
		chk(last_addr, 32'h1018);
	endtask : t_desc
	task automatic t_swr();
		int i;
		wr(8'h80, 32'h81);
		for (i = 0; i < 10 && dma_soft_reset !== 1'b1; i++)
			@(posedge pclk);
		chk({31'h0, dma_soft_reset}, 32'h1);
		rd(8'h80, 32'h80);
		wr(8'h80, 32'h0);
	endtask : t_swr
	initial begin
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_reset();
		t_burst();
		t_wp_count();
		t_level();
		t_desc();
		t_swr();
		report_and_stop();
	end
endmodule : chfd_top_tb
bind chfd_top chfd_sva u_sva (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
	.pready, .fifo_count, .xfer_to_card, .desc_rd_valid, .desc_rd_own, .desc_rd_req,
	.desc_rd_addr, .dma_req, .burst_words, .fixed_length_bursts, .dma_on_switch,
	.dma_soft_reset);
